// [rtl/i2ccm_top.v]
// I2C configuration master: register port, quarter-period timer and the
// single transaction sequencer driving open-drain clock and data pins.
// Assumes external pull-ups; pins return through pad inputs, core clock only.
//
// Notes on behaviour
// - Lines only pulled low or released
// - Start and stop with clock high
// - Interval counters programmed by software
// - Software delay shifts the first data transition after start
// - Two or three phase transactions
// - Eight bits then acknowledge each phase
// - Peripheral acks writes; controller nacks the read byte
// - Address byte: seven bits plus direction
// - Data mismatch while high loses arbitration
// - Arbitration checked only when driving data
// - Wait while clock held low after release
// - One sequencer kicked by register writes
// - Manual start runs phases, acks, holds bus
// - Manual stop issues stop, flags stop
// - Auto mode runs to stop, flags stop
// - Restart sends address with the direction bit held in slv_addr
// - Read byte lands in slave data register
// - Transitions on quarter clock periods
`timescale 1ns/10ps
`default_nettype none
`include "i2ccm_defines.vh"

module i2ccm_top
(
  input  wire        core_clk_in,   // 20 MHz core clock
  input  wire        sys_rst_in,    // Synchronous reset, active high
  input  wire [3:0]  reg_addr_in,   // Register word index
  input  wire [7:0]  reg_wdata_in,  // Register write data
  input  wire        reg_wr_in,     // Write strobe
  input  wire        reg_rd_in,     // Read strobe
  output reg  [15:0] reg_rdata_out, // Read data, cycle after strobe
  input  wire        scl_in,        // Clock pad input
  output wire        scl_out,       // Clock pad output, always low
  output reg         scl_oe_out,    // Clock pull-low enable
  input  wire        sda_in,        // Data pad input
  output wire        sda_out,       // Data pad output, always low
  output reg         sda_oe_out     // Data pull-low enable
);

  // States
  localparam [3:0] ST_IDLE  = 4'h0; // Bus free
  localparam [3:0] ST_START = 4'h1; // Start condition
  localparam [3:0] ST_BIT   = 4'h2; // Data or ack bit
  localparam [3:0] ST_HOLD  = 4'h3; // Bus held, clock low
  localparam [3:0] ST_STOP  = 4'h4; // Stop condition
  localparam [3:0] ST_RSTRT = 4'h5; // Repeated start lead-in

  // Software registers
  reg  [7:0]  cfg1;        // first_configuration_register
  reg  [15:0] qtr_cnt;     // Quarter-period terminal count
  reg  [15:0] setup_cnt;   // Start/stop hold interval count
  reg  [7:0]  dly_cnt;     // Delay from start clock low to first data bit
  reg  [7:0]  slv_addr;    // Slave id and direction bit
  reg  [7:0]  tgt_addr;    // Target internal address
  reg  [7:0]  tgt_data;    // Write data
  reg  [7:0]  slv_data;    // Captured read data
  reg         st_ack;      // Sticky acknowledge event
  reg         st_stop;     // Sticky stop event
  reg         st_arb;      // Sticky arbitration lost
  reg         st_nack;     // Sticky not-acknowledged
  reg         start_req;   // Pending start kick
  reg         stop_req;    // Pending stop kick

  // Pin synchronisers; only the second stage is read
  reg  [1:0]  scl_sync;    // Clock pin sync chain
  reg  [1:0]  sda_sync;    // Data pin sync chain
  wire        scl_s;       // Synchronised clock
  wire        sda_s;       // Synchronised data

  // Sequencer state
  reg  [3:0]  state;       // Current state
  reg  [1:0]  quarter;     // Quarter within bit
  reg  [15:0] tmr;         // Interval timer
  reg  [3:0]  bit_idx;     // 0..7 data, 8 ack
  reg  [1:0]  phase;       // Phase number in transaction
  reg  [7:0]  shreg;       // Shift register
  reg         sda_want;    // Level the master wants on data
  reg         is_read;     // Current transaction reads
  reg         addr_sent;   // Last phase completed since start from idle

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_s   = scl_sync[1];
  assign sda_s   = sda_sync[1];

  // Two-flop synchronisers on both pads
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
    end
  end

  // Read mux; unmapped words read zero
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 16'h0000;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `I2CCM_REG_CFG1:     reg_rdata_out <= {8'h00, cfg1};
        `I2CCM_REG_CFG2:     reg_rdata_out <= qtr_cnt;
        `I2CCM_REG_CFG3:     reg_rdata_out <= {dly_cnt, setup_cnt[7:0]};
        `I2CCM_REG_SLV_ADDR: reg_rdata_out <= {8'h00, slv_addr};
        `I2CCM_REG_TGT_ADDR: reg_rdata_out <= {8'h00, tgt_addr};
        `I2CCM_REG_TGT_DATA: reg_rdata_out <= {8'h00, tgt_data};
        `I2CCM_REG_CTRL:
          reg_rdata_out <= {14'h0000, stop_req, start_req};
        `I2CCM_REG_STATUS:
          reg_rdata_out <= {10'h000, (state == ST_HOLD),
                            (state != ST_IDLE), st_nack, st_arb,
                            st_stop, st_ack};
        `I2CCM_REG_SLV_DATA: reg_rdata_out <= {8'h00, slv_data};
        default:             reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  // Configuration writes; CFG3 sets setup count, delay is written at the status index
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      cfg1      <= `I2CCM_CFG1_RST;
      qtr_cnt   <= `I2CCM_QTR_RST;
      setup_cnt <= `I2CCM_SETUP_RST;
      dly_cnt   <= `I2CCM_DLY_RST;
      slv_addr  <= 8'h00;
      tgt_addr  <= 8'h00;
      tgt_data  <= 8'h00;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `I2CCM_REG_CFG1:     cfg1 <= reg_wdata_in;
        `I2CCM_REG_CFG2:     qtr_cnt <= {8'h00, reg_wdata_in};
        `I2CCM_REG_CFG3:     setup_cnt <= {8'h00, reg_wdata_in};
        `I2CCM_REG_SLV_ADDR: slv_addr <= reg_wdata_in;
        `I2CCM_REG_TGT_ADDR: tgt_addr <= reg_wdata_in;
        `I2CCM_REG_TGT_DATA: tgt_data <= reg_wdata_in;
        `I2CCM_REG_STATUS:   dly_cnt <= reg_wdata_in;
        default:             cfg1 <= cfg1;
      endcase
    end
  end

  // Byte sent in a given phase: address, internal address, data
  wire [7:0] phase_byte = (phase == 2'h0) ? slv_addr :
                          (phase == 2'h1) ? tgt_addr : tgt_data;
  wire       three_ph   = cfg1[`I2CCM_CFG1_3PH_BIT];
  wire       auto_mode  = cfg1[`I2CCM_CFG1_AUTO_BIT];
  // Last phase of this transaction
  wire [1:0] last_ph    = is_read ? 2'h1 : (three_ph ? 2'h2 : 2'h1);
  // Master drives data during address and write phases only
  wire       drives     = (phase == 2'h0) || !is_read;
  wire       tmr_done   = (tmr == 16'h0000);
  wire       ctrl_wr    = reg_wr_in && (reg_addr_in == `I2CCM_REG_CTRL);
  wire       stat_wr    = reg_wr_in && (reg_addr_in == `I2CCM_REG_STATUS);

  // Sequencer: one timer tick per quarter; clock stretch freezes the tick
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      state      <= ST_IDLE;
      quarter    <= 2'h0;
      tmr        <= 16'h0000;
      bit_idx    <= 4'h0;
      phase      <= 2'h0;
      shreg      <= 8'h00;
      sda_want   <= 1'b1;
      is_read    <= 1'b0;
      addr_sent  <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      slv_data   <= 8'h00;
      st_ack     <= 1'b0;
      st_stop    <= 1'b0;
      st_arb     <= 1'b0;
      st_nack    <= 1'b0;
      start_req  <= 1'b0;
      stop_req   <= 1'b0;
    end
    else
    begin
      // Kicks latch until taken; a write-one clears status (set wins below)
      if (ctrl_wr && reg_wdata_in[`I2CCM_CTRL_START_BIT])
        start_req <= 1'b1;
      if (ctrl_wr && reg_wdata_in[`I2CCM_CTRL_STOP_BIT])
        stop_req <= 1'b1;
      if (stat_wr)
      begin
        if (reg_wdata_in[`I2CCM_ST_ACK_BIT])  st_ack  <= 1'b0;
        if (reg_wdata_in[`I2CCM_ST_STOP_BIT]) st_stop <= 1'b0;
        if (reg_wdata_in[`I2CCM_ST_ARB_BIT])  st_arb  <= 1'b0;
        if (reg_wdata_in[`I2CCM_ST_NACK_BIT]) st_nack <= 1'b0;
      end
      sda_oe_out <= !sda_want;
      if (!tmr_done)
        tmr <= tmr - 16'h0001;
      case (state)
        ST_IDLE:
        begin
          scl_oe_out <= 1'b0;
          sda_want   <= 1'b1;
          if (start_req)
          begin
            start_req <= 1'b0;
            stop_req  <= 1'b0;
            is_read   <= slv_addr[0];
            phase     <= 2'h0;
            addr_sent <= 1'b0;
            tmr       <= setup_cnt;
            state     <= ST_START;
          end
        end
        ST_START:
        begin
          // Data falls while clock is high, then clock falls
          if (tmr_done && scl_s)
          begin
            if (sda_want)
            begin
              sda_want <= 1'b0;
              tmr      <= setup_cnt;
            end
            else
            begin
              scl_oe_out <= 1'b1;
              shreg      <= phase_byte;
              bit_idx    <= 4'h0;
              quarter    <= 2'h0;
              tmr        <= {8'h00, dly_cnt};
              state      <= ST_BIT;
            end
          end
        end
        ST_BIT:
        begin
          if (tmr_done)
          begin
            case (quarter)
              2'h0:
              begin
                // Clock low: data changes here, after the delay on the first bit, else a quarter
                if (bit_idx == 4'h8)
                  sda_want <= drives ||
                              (phase == last_ph && !auto_mode) ? 1'b1
                              : (phase != last_ph) ? 1'b0 : 1'b1;
                else if (drives)
                  sda_want <= shreg[7];
                else
                  sda_want <= 1'b1;
                quarter <= 2'h1;
                tmr     <= qtr_cnt;
              end
              2'h1:
              begin
                scl_oe_out <= 1'b0;
                quarter    <= 2'h2;
                tmr        <= qtr_cnt;
              end
              2'h2:
              begin
                // Stretch: hold here until clock actually rises
                if (scl_s)
                begin
                  if (bit_idx != 4'h8 && drives && sda_want && !sda_s)
                  begin
                    st_arb     <= 1'b1;
                    sda_want   <= 1'b1;
                    scl_oe_out <= 1'b0;
                    state      <= ST_IDLE;
                  end
                  else
                  begin
                    if (bit_idx == 4'h8 && drives && sda_s)
                      st_nack <= 1'b1;
                    if (bit_idx != 4'h8)
                      shreg <= {shreg[6:0], sda_s};
                    quarter <= 2'h3;
                    tmr     <= qtr_cnt;
                  end
                end
              end
              default:
              begin
                scl_oe_out <= 1'b1;
                quarter    <= 2'h0;
                tmr        <= qtr_cnt;
                if (bit_idx != 4'h8)
                  bit_idx <= bit_idx + 4'h1;
                else
                begin
                  bit_idx <= 4'h0;
                  if (!drives)
                    slv_data <= shreg;
                  if (phase == last_ph ||
                      (!auto_mode && !is_read && phase == 2'h1 &&
                       !three_ph))
                  begin
                    addr_sent <= 1'b1;
                    if (auto_mode)
                      state <= ST_STOP;
                    else
                    begin
                      st_ack <= 1'b1;
                      state  <= ST_HOLD;
                    end
                  end
                  else
                  begin
                    phase <= phase + 2'h1;
                    shreg <= (phase == 2'h0) ?
                             (is_read ? 8'hFF : tgt_addr) : tgt_data;
                  end
                end
              end
            endcase
          end
        end
        ST_HOLD:
        begin
          // Clock held low awaiting a further command
          sda_want <= sda_want;
          if (stop_req)
          begin
            stop_req <= 1'b0;
            sda_want <= 1'b0;
            tmr      <= qtr_cnt;
            state    <= ST_STOP;
          end
          else if (start_req)
          begin
            start_req <= 1'b0;
            is_read   <= slv_addr[0];
            phase     <= 2'h0;
            sda_want  <= 1'b1;
            tmr       <= qtr_cnt;
            state     <= ST_RSTRT;
          end
        end
        ST_RSTRT:
        begin
          // Release clock with data high, then reuse start sequence
          if (tmr_done)
          begin
            scl_oe_out <= 1'b0;
            tmr        <= setup_cnt;
            state      <= ST_START;
          end
        end
        ST_STOP:
        begin
          // Data low, clock released, then data rises with clock high
          if (scl_oe_out)
          begin
            sda_want <= 1'b0;
            // Let the clock go only once data is low at the pad; releasing
            // both in one cycle would look like a start to the peripheral
            if (tmr_done && sda_oe_out)
            begin
              scl_oe_out <= 1'b0;
              tmr        <= setup_cnt;
            end
          end
          else if (tmr_done && scl_s)
          begin
            sda_want <= 1'b1;
            st_stop  <= 1'b1;
            state    <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule // i2ccm_top
`default_nettype wire

// [rtl/i2ccm_defines.vh]
// Constants for the I2C configuration master: register offsets, field
// positions, reset values and default timing counts.
// Assumes inclusion by bare name from files in rtl/.
`ifndef I2CCM_DEFINES_VH
`define I2CCM_DEFINES_VH

// Register offsets (word index on the plain register port)
`define I2CCM_REG_CFG1        4'h0
`define I2CCM_REG_CFG2        4'h1
`define I2CCM_REG_CFG3        4'h2
`define I2CCM_REG_SLV_ADDR    4'h3
`define I2CCM_REG_TGT_ADDR    4'h4
`define I2CCM_REG_TGT_DATA    4'h5
`define I2CCM_REG_CTRL        4'h6
`define I2CCM_REG_STATUS      4'h7
`define I2CCM_REG_SLV_DATA    4'h8

// First configuration register fields
`define I2CCM_CFG1_AUTO_BIT   0
`define I2CCM_CFG1_3PH_BIT    1
// Control register fields
`define I2CCM_CTRL_START_BIT  0
`define I2CCM_CTRL_STOP_BIT   1
// Status register fields (write one to clear sticky bits)
`define I2CCM_ST_ACK_BIT      0
`define I2CCM_ST_STOP_BIT     1
`define I2CCM_ST_ARB_BIT      2
`define I2CCM_ST_NACK_BIT     3
`define I2CCM_ST_BUSY_BIT     4
`define I2CCM_ST_HOLD_BIT     5

// Reset values
`define I2CCM_CFG1_RST        8'h02
`define I2CCM_QTR_RST         16'h000C
`define I2CCM_SETUP_RST       16'h0019
`define I2CCM_DLY_RST         8'h02

`endif

// [tb/i2ccm_checker.sv]
// Port checker for the I2C configuration master.
// Assumes the bench resolves each pad: low when any party pulls it.
`timescale 1ns/10ps
`default_nettype none
module i2ccm_checker
(
  input wire logic        core_clk_in,   // Core clock
  input wire logic        sys_rst_in,    // Sync reset
  input wire logic [3:0]  reg_addr_in,   // Word index
  input wire logic [7:0]  reg_wdata_in,  // Write data
  input wire logic        reg_wr_in,     // Write strobe
  input wire logic        reg_rd_in,     // Read strobe
  input wire logic [15:0] reg_rdata_out, // Read data
  input wire logic        scl_in,        // Clock line level
  input wire logic        scl_out,       // Clock pad value
  input wire logic        scl_oe_out,    // Clock pull enable
  input wire logic        sda_in,        // Data line level
  input wire logic        sda_out,       // Data pad value
  input wire logic        sda_oe_out     // Data pull enable
);
  // One quarter is two core cycles at the bench setting
  localparam int MIN_GAP = 1;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic       scl_oe_q; // Clock enable one cycle back
  logic [3:0] gap;      // Cycles since the clock enable moved
  // Saturating rest counter; saturated after reset so no false start
  always @(posedge core_clk_in)
  begin
    scl_oe_q <= sys_rst_in ? 1'b0 : scl_oe_out;
    if (sys_rst_in || (scl_oe_out == scl_oe_q && gap == 4'hF))
      gap <= 4'hF;
    else if (scl_oe_out != scl_oe_q)
      gap <= 4'h0;
    else
      gap <= gap + 4'h1;
  end
  a_pads_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pad value not low");
  a_reset_free: assert property ($fell(sys_rst_in) |->
    !scl_oe_out && !sda_oe_out) else $error("lines pulled after reset");
  a_start_clk_high: assert property ($rose(sda_oe_out) && !scl_oe_out
    |-> scl_in) else $error("data fell with clock low");
  a_stop_clk_high: assert property ($fell(sda_oe_out) && !scl_oe_out
    |-> scl_in) else $error("data rose with clock low");
  a_stop_then_idle: assert property ($fell(sda_oe_out) && !scl_oe_out
    |=> (!sda_oe_out && !scl_oe_out) [*3]) else $error("data moved in high");
  a_stretch_pause: assert property (!scl_oe_out && !scl_in
    |=> !scl_oe_out && $stable(sda_oe_out)) else $error("ran on stretch");
  a_clock_spacing: assert property (scl_oe_out != scl_oe_q
    |-> gap >= MIN_GAP) else $error("clock edge under a quarter");
  a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > 4'h8
    |=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
  a_cfg_readback: assert property (reg_wr_in && reg_addr_in == 4'h0 ##2
    reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[1:0] ==
    $past(reg_wdata_in[1:0], 3)) else $error("mode bits not kept");
endmodule // i2ccm_checker
`default_nettype wire

// [tb/i2ccm_slave_model.sv]
// Behavioural I2C peripheral: acks its address, logs written bytes,
// returns one fixed byte on reads and stretches the clock after acks.
// Assumes open-drain lines resolved by the bench with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module i2ccm_slave_model
#(
  parameter logic [6:0] ID      = 7'h50, // Own address
  parameter logic [7:0] RD_BYTE = 8'hA5, // Byte returned on reads
  parameter int         STR_NS  = 900    // Stretch after every ack
)
(
  input  wire logic scl_in,       // Resolved clock line
  input  wire logic sda_in,       // Resolved data line
  output var  logic scl_pull_out, // High pulls clock low
  output var  logic sda_pull_out  // High pulls data low
);
  logic [7:0] sh;         // Incoming bits
  int         bits = 0;   // Clock rises since start or last ack
  logic       rd = 1'b0;  // Direction from the address byte
  logic       sel = 1'b0; // Our address was seen
  logic       adr = 1'b0; // Address phase in progress
  logic [7:0] log_q[$];   // Bytes the master wrote
  initial
  begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
  end
  // Start or repeated start: data falls while clock high
  always @(negedge sda_in)
    if (scl_in)
    begin
      bits = 0;
      adr = 1'b1;
      sda_pull_out = 1'b0;
    end
  // Sample on clock rise, first bit is most significant
  always @(posedge scl_in)
  begin
    if (bits < 8)
      sh = {sh[6:0], sda_in};
    bits = bits + 1;
  end
  // Our own data moves only while the clock is low
  always @(negedge scl_in)
  begin
    if (bits == 8 && (adr || !rd))
    begin
      log_q.push_back(sh);
      sel = adr ? (sh[7:1] == ID) : sel;
      rd = adr ? sh[0] : rd;
      sda_pull_out = sel;
    end
    else if (bits == 8)
      sda_pull_out = 1'b0; // Release data; master sends not-ack on our byte
    else if (bits == 9)
    begin
      // First read bit is set up before the stall ends, never at the rise
      sda_pull_out = (adr && rd && sel) ? !RD_BYTE[7] : 1'b0;
      bits = 0;
      adr = 1'b0;
      scl_pull_out = 1'b1;
      #(STR_NS);
      scl_pull_out = 1'b0;
    end
    else if (bits < 8 && rd && sel && !adr)
      sda_pull_out = !RD_BYTE[7 - bits];
  end
endmodule // i2ccm_slave_model
`default_nettype wire

// [tb/i2ccm_top_tb.sv]
// Bench for the I2C configuration master: register tasks, one peripheral
// model, a rival master pulling data low; assumes pull-ups on both lines.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
module i2ccm_top_tb;
  localparam logic [6:0] ID = 7'h50;      // Peripheral address
  localparam logic [7:0] RD_BYTE = 8'hA5; // Peripheral read byte
  logic        core_clk_in = 1'b0;  // Core clock
  logic        sys_rst_in = 1'b1;   // Reset
  logic [3:0]  reg_addr_in = 4'h0;  // Register index
  logic [7:0]  reg_wdata_in = 8'h00; // Write data
  logic        reg_wr_in = 1'b0;    // Write strobe
  logic        reg_rd_in = 1'b0;    // Read strobe
  logic        tb_pull = 1'b0;      // Rival master on data
  logic [15:0] d;                   // Last read value
  wire  [15:0] reg_rdata_out;
  wire         scl_out, scl_oe_out, sda_out, sda_oe_out;
  wire         scl_pull, sda_pull;
  wire         scl_in = !(scl_oe_out || scl_pull);
  wire         sda_in = !(sda_oe_out || sda_pull || tb_pull);
  int          compares = 0;
  int          miscompares = 0;
  int          lp = 0;              // Next logged byte to check
  always #25 core_clk_in = !core_clk_in;
  i2ccm_top i2ccm_top_inst (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
  i2ccm_slave_model #(.ID(ID), .RD_BYTE(RD_BYTE)) i2ccm_slave_model_inst
    (.scl_in(scl_in), .sda_in(sda_in), .scl_pull_out(scl_pull),
    .sda_pull_out(sda_pull));
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  // Poll a status flag; a bounded wait so a dead sequencer shows
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    rd(4'h7, d);
    while (d[b] !== 1'b1 && n < 4000)
    begin
      rd(4'h7, d);
      n++;
    end
    `CHK("status flag", 1'b1, d[b])
  endtask
  task automatic byte_is(input logic [7:0] e);
    `CHK("slave byte", e, i2ccm_slave_model_inst.log_q[lp])
    lp++;
  endtask
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well above the few thousand cycles the tests need
  initial
  begin
    repeat (60000) @(posedge core_clk_in);
    miscompares++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    rd(4'h0, d); `CHK("cfg1 reset", 16'h0002, d)
    rd(4'h1, d); `CHK("quarter reset", 16'h000C, d)
    rd(4'h2, d); `CHK("setup reset", 16'h0219, d)
    rd(4'hF, d); `CHK("unmapped", 16'h0000, d)
    // Quarter of two cycles, plus one sync cycle on the rise, gives a 450 ns clock before the delay
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h03);
    wr(4'h7, 8'h0F);
    rd(4'h2, d); `CHK("delay setup", 16'h0F03, d)
    // Automatic three-phase write
    wr(4'h0, 8'h03);
    rd(4'h0, d); `CHK("mode bits", 2'b11, d[1:0])
    wr(4'h3, {ID, 1'b0});
    wr(4'h4, 8'h12);
    wr(4'h5, 8'h34);
    wr(4'h6, 8'h01);
    wait_bit(1);
    byte_is({ID, 1'b0});
    byte_is(8'h12);
    byte_is(8'h34);
    rd(4'h7, d); `CHK("auto flags", 4'b0010, d[3:0])
    // Manual write of the index, restart for read, then stop
    wr(4'h7, 8'h0F);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h12);
    wr(4'h6, 8'h01);
    wait_bit(0);
    `CHK("bus held", 2'b11, {d[5], scl_oe_out})
    byte_is({ID, 1'b0});
    byte_is(8'h12);
    wr(4'h7, 8'h0F);
    wr(4'h3, {ID, 1'b1});
    wr(4'h6, 8'h01);
    wait_bit(0);
    byte_is({ID, 1'b1});
    wr(4'h7, 8'h0F);
    wr(4'h6, 8'h02);
    wait_bit(1);
    `CHK("peer acked", 1'b0, d[3])
    rd(4'h8, d); `CHK("read byte", {8'h00, RD_BYTE}, d)
    // Unknown address: nobody acks, the run still ends in a stop
    wr(4'h7, 8'h0F);
    wr(4'h0, 8'h03);
    wr(4'h3, {ID + 7'h01, 1'b0});
    wr(4'h6, 8'h01);
    wait_bit(1);
    rd(4'h7, d); `CHK("nack flags", 4'b1010, d[3:0])
    // Rival master holds data low while ours sends a one
    wr(4'h7, 8'h0F);
    wr(4'h0, 8'h03);
    wr(4'h3, {ID, 1'b0});
    wr(4'h6, 8'h01);
    wait (sda_oe_out);
    wait (scl_oe_out);
    wait (!scl_oe_out);
    tb_pull <= 1'b1;
    wait_bit(2);
    `CHK("lines freed", 2'b00, {scl_oe_out, sda_oe_out})
    tb_pull <= 1'b0;
    report_and_stop;
  end
endmodule // i2ccm_top_tb
bind i2ccm_top i2ccm_checker i2ccm_checker_inst (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
`default_nettype wire
